/* verilog/ctc_tx_request_ctrl.sv */
// Transmit buffer request, abort, status flags, priority pick and request pins.
//
// Notes on behaviour
// [RULE1] Host sets pending bit to send; device clears it once the message is sent.
// [RULE2] Host clearing a pending bit aborts; aborted flag set, zero after good send.
// [RULE3] Lost-arbitration flag set when the buffer loses arbitration, else zero.
// [RULE4] Transmit-error flag set on bus error while sending the buffer, else zero.
// [RULE5] Two-bit priority orders pending buffers, 11 highest, 00 lowest.
// [RULE6] With pin mode set, a falling pin edge requests its buffer's transmission.
// [RULE7] With pin mode clear, the pin is a digital input readable in bits 3..5.
`timescale 1ns/10ps
module ctc_tx_request_ctrl
  import ctc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Register access port, bit-maskable writes.
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [DATA_W-1:0] reg_wr_data,
  input wire logic [DATA_W-1:0] reg_wr_mask,
  input wire logic reg_rd_en,
  output logic [DATA_W-1:0] reg_rd_data_q,
  // Request pins, asynchronous.
  input wire logic [NUM_BUF-1:0] request_pin,
  // Transmit engine reports, same clock.
  input wire logic eng_sent,
  input wire logic eng_lost_arb,
  input wire logic eng_bus_err,
  input wire logic [1:0] eng_buf,
  // Pending state and next buffer to send.
  output logic [NUM_BUF-1:0] pending_transmit_q,
  output logic next_valid_q,
  output logic [1:0] next_buf_q
);

  logic [NUM_BUF-1:0] aborted_flag_q;
  logic [NUM_BUF-1:0] lost_arbitration_flag_q;
  logic [NUM_BUF-1:0] transmit_error_flag_q;
  logic [1:0] buffer_priority_q [NUM_BUF];
  logic [NUM_BUF-1:0] pin_request_mode_q;
  logic [NUM_BUF-1:0] pin_sync1_q;
  logic [NUM_BUF-1:0] pin_sync2_q;
  logic [NUM_BUF-1:0] pin_prev_q;
  logic [NUM_BUF-1:0] pin_fall;
  logic [DATA_W-1:0] buf_ctl [NUM_BUF];
  logic [DATA_W-1:0] pin_ctl;
  logic [DATA_W-1:0] pin_ctl_new;
  logic [DATA_W-1:0] rd_d;

  // Applies a bit-masked write to an old register value.
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_v,
                                              input logic [DATA_W-1:0] data_v,
                                              input logic [DATA_W-1:0] mask_v);
    merge = (old_v & ~mask_v) | (data_v & mask_v);
  endfunction

  // Offset of a buffer control register.
  function automatic logic [ADDR_W-1:0] buf_ofs(input int idx);
    case (idx)
      0: buf_ofs = OFS_TXB0;
      1: buf_ofs = OFS_TXB1;
      default: buf_ofs = OFS_TXB2;
    endcase
  endfunction

  // Picks the pending buffer of highest priority; on a tie the higher buffer wins.
  function automatic logic [1:0] pick(input logic [NUM_BUF-1:0] pend,
                                      input logic [1:0] prio [NUM_BUF]);
    logic [1:0] best;
    logic [1:0] best_p;
    logic found;
    best = 2'h0;
    best_p = 2'h0;
    found = 1'b0;
    for (int k = 0; k < NUM_BUF; k++)
    begin
      if (pend[k] && (!found || prio[k] >= best_p))
      begin
        best = 2'(k);
        best_p = prio[k];
        found = 1'b1;
      end
    end
    pick = best;
  endfunction

  // Two-flop synchroniser, then a third flop for edge detection only.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pin_sync1_q <= '0;
      pin_sync2_q <= '0;
      pin_prev_q <= '0;
    end
    else
    begin
      pin_sync1_q <= request_pin;
      pin_sync2_q <= pin_sync1_q;
      pin_prev_q <= pin_sync2_q;
    end
  end

  assign pin_fall = pin_prev_q & ~pin_sync2_q;

  // Masked write value for the pin register; a net, since a call cannot be part-selected.
  assign pin_ctl_new = merge(pin_ctl, reg_wr_data, reg_wr_mask);

  // Pin mode bits; the state bits are read-only and ignore writes.
  always_ff @(posedge clk)
  begin
    if (srst)
      pin_request_mode_q <= RST_MODE;
    else if (reg_wr_en && reg_addr == OFS_PIN_CTRL)
      pin_request_mode_q <= pin_ctl_new[PIN_MODE_LSB +: NUM_BUF];
  end

  // The state bits show the synchronised level in either mode.
  assign pin_ctl = {2'h0, pin_sync2_q, pin_request_mode_q}; // RULE7

  for (genvar i = 0; i < NUM_BUF; i++)
  begin : g_buf
    logic [DATA_W-1:0] ctl_new;
    logic wr_hit;
    logic host_set;
    logic host_clr;
    logic pin_set;
    logic new_req;
    logic eng_hit;
    logic sent_clr;

    assign buf_ctl[i] = {1'b0, aborted_flag_q[i], lost_arbitration_flag_q[i],
                         transmit_error_flag_q[i], pending_transmit_q[i], 1'b0,
                         buffer_priority_q[i]};
    assign ctl_new = merge(buf_ctl[i], reg_wr_data, reg_wr_mask);
    assign wr_hit = reg_wr_en && reg_addr == buf_ofs(i);
    assign host_set = wr_hit && ctl_new[BIT_PEND] && !pending_transmit_q[i];
    assign host_clr = wr_hit && !ctl_new[BIT_PEND] && pending_transmit_q[i];
    assign pin_set = pin_fall[i] && pin_request_mode_q[i]; // RULE6
    assign new_req = host_set || pin_set;
    assign eng_hit = eng_buf == 2'(i) && pending_transmit_q[i];
    assign sent_clr = eng_sent && eng_hit;

    // Pending bit: a new request wins over a completion or abort in the same cycle.
    always_ff @(posedge clk)
    begin
      if (srst)
        pending_transmit_q[i] <= 1'b0;
      else if (new_req)
        pending_transmit_q[i] <= 1'b1; // RULE1
      else if (host_clr || sent_clr)
        pending_transmit_q[i] <= 1'b0; // RULE1
    end

    // Aborted flag; a message that finished as the abort arrived counts as sent.
    always_ff @(posedge clk)
    begin
      if (srst)
        aborted_flag_q[i] <= 1'b0;
      else if (host_clr && !sent_clr)
        aborted_flag_q[i] <= 1'b1; // RULE2
      else if (new_req || sent_clr)
        aborted_flag_q[i] <= 1'b0; // RULE2
    end

    // Status flags are cleared when a fresh request is made; a set wins.
    always_ff @(posedge clk)
    begin
      if (srst)
      begin
        lost_arbitration_flag_q[i] <= 1'b0;
        transmit_error_flag_q[i] <= 1'b0;
      end
      else
      begin
        if (eng_lost_arb && eng_hit)
          lost_arbitration_flag_q[i] <= 1'b1; // RULE3
        else if (new_req)
          lost_arbitration_flag_q[i] <= 1'b0; // RULE3
        if (eng_bus_err && eng_hit)
          transmit_error_flag_q[i] <= 1'b1; // RULE4
        else if (new_req)
          transmit_error_flag_q[i] <= 1'b0; // RULE4
      end
    end

    // Priority field; the pending bit is handled above, the other bits of the write are read-only or unused.
    always_ff @(posedge clk)
    begin
      if (srst)
        buffer_priority_q[i] <= RST_PRIO;
      else if (wr_hit)
        buffer_priority_q[i] <= ctl_new[PRIO_LSB +: 2];
    end

    sequence sent_seq;
      eng_sent && eng_hit && !new_req;
    endsequence

    sequence abort_seq;
      host_clr && !sent_clr && !new_req;
    endsequence

    sequence pin_fall_seq;
      request_pin[i] ##1 (!request_pin[i] && pin_request_mode_q[i])[*3];
    endsequence

    pend_clear_a: assert property (@(posedge clk) disable iff (srst) // RULE1
      sent_seq |=> !pending_transmit_q[i] && !aborted_flag_q[i])
      else $error("pending bit not cleared after send");

    abort_flag_a: assert property (@(posedge clk) disable iff (srst) // RULE2
      abort_seq |=> aborted_flag_q[i] && !pending_transmit_q[i])
      else $error("abort not reported");

    lost_flag_a: assert property (@(posedge clk) disable iff (srst) // RULE3
      (eng_lost_arb && eng_hit) |=> lost_arbitration_flag_q[i])
      else $error("lost arbitration flag not set");

    lost_quiet_a: assert property (@(posedge clk) disable iff (srst) // RULE3
      (!lost_arbitration_flag_q[i] && !(eng_lost_arb && eng_hit))
        |=> !lost_arbitration_flag_q[i])
      else $error("lost arbitration flag set without cause");

    err_flag_a: assert property (@(posedge clk) disable iff (srst) // RULE4
      (eng_bus_err && eng_hit) |=> transmit_error_flag_q[i])
      else $error("transmit error flag not set");

    pin_request_a: assert property (@(posedge clk) disable iff (srst) // RULE6
      pin_fall_seq |=> pending_transmit_q[i])
      else $error("pin falling edge did not request transmission");

    // Four samples cover the two synchroniser flops even right after reset.
    pin_level_a: assert property (@(posedge clk) disable iff (srst) // RULE7
      request_pin[i][*4] |-> pin_ctl[PIN_STATE_LSB + i])
      else $error("pin state bit does not follow the pin");
  end

  // Next buffer to send, picked by priority.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      next_valid_q <= 1'b0;
      next_buf_q <= 2'h0;
    end
    else
    begin
      next_valid_q <= |pending_transmit_q;
      next_buf_q <= pick(pending_transmit_q, buffer_priority_q); // RULE5
    end
  end

  prio_order_a: assert property (@(posedge clk) disable iff (srst) // RULE5
    (pending_transmit_q[0] && pending_transmit_q[1] && !pending_transmit_q[2]
      && buffer_priority_q[1] > buffer_priority_q[0]) |=> next_buf_q == 2'h1)
    else $error("lower priority buffer picked first");

  prio_high_a: assert property (@(posedge clk) disable iff (srst) // RULE5
    (pending_transmit_q[0] && pending_transmit_q[2] && !pending_transmit_q[1]
      && buffer_priority_q[0] == 2'h3 && buffer_priority_q[2] == 2'h0)
      |=> next_buf_q == 2'h0)
    else $error("priority 11 not treated as highest");

  // Read data mux; unmapped addresses and reserved bits read zero.
  always_comb
  begin
    case (reg_addr)
      OFS_PIN_CTRL: rd_d = pin_ctl;
      OFS_TXB0: rd_d = buf_ctl[0];
      OFS_TXB1: rd_d = buf_ctl[1];
      OFS_TXB2: rd_d = buf_ctl[2];
      default: rd_d = RST_RD;
    endcase
  end

  // Read data is captured on the read strobe and held until the next read.
  always_ff @(posedge clk)
  begin
    if (srst)
      reg_rd_data_q <= RST_RD;
    else if (reg_rd_en)
      reg_rd_data_q <= rd_d;
  end

endmodule

/* common/ctc_pkg.sv */
// Constants for the transmit buffer request control block.
package ctc_pkg;
  // Register port widths.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NUM_BUF = 3;
  // Register offsets.
  localparam logic [7:0] OFS_PIN_CTRL = 8'h0d;
  localparam logic [7:0] OFS_TXB0 = 8'h30;
  localparam logic [7:0] OFS_TXB1 = 8'h40;
  localparam logic [7:0] OFS_TXB2 = 8'h50;
  // Field positions in a buffer control register.
  localparam int BIT_ABORTED = 6;
  localparam int BIT_LOST = 5;
  localparam int BIT_ERR = 4;
  localparam int BIT_PEND = 3;
  localparam int PRIO_LSB = 0;
  // Field positions in the pin control and status register.
  localparam int PIN_MODE_LSB = 0;
  localparam int PIN_STATE_LSB = 3;
  // Values after reset.
  localparam logic [1:0] RST_PRIO = 2'h0;
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [7:0] RST_RD = 8'h00;
endpackage

/* verification/ctc_eng_model.sv */
// Behavioural transmit engine that reports sent, lost and error events.
`timescale 1ns/10ps
module ctc_eng_model
(
  // Clock.
  input wire logic clk,
  // Engine reports.
  output logic eng_sent,
  output logic eng_lost_arb,
  output logic eng_bus_err,
  output logic [1:0] eng_buf
);
  // Idle outputs at time zero; the index is scrambled when idle so no stale value helps.
  initial
  begin
    eng_sent = 1'b0;
    eng_lost_arb = 1'b0;
    eng_bus_err = 1'b0;
    eng_buf = 2'h3;
  end

  // One-cycle pulse of the chosen kind: bit 0 sent, bit 1 lost, bit 2 error.
  task automatic fire(input logic [2:0] k, input logic [1:0] b);
    @(posedge clk);
    eng_sent <= k[0];
    eng_lost_arb <= k[1];
    eng_bus_err <= k[2];
    eng_buf <= b;
    @(posedge clk);
    eng_sent <= 1'b0;
    eng_lost_arb <= 1'b0;
    eng_bus_err <= 1'b0;
    eng_buf <= ~b;
  endtask
endmodule

/* verification/ctc_tx_request_ctrl_tb.sv */
// Self-checking bench for the transmit buffer request control block.
`timescale 1ns/10ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, a); end end
module ctc_tx_request_ctrl_tb;
  import ctc_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wr_data = 8'h00;
  logic [7:0] reg_wr_mask = 8'h00;
  logic reg_rd_en = 1'b0;
  logic [7:0] rd_q;
  logic [2:0] request_pin = 3'h7;
  logic eng_sent, eng_lost_arb, eng_bus_err;
  logic [1:0] eng_buf;
  logic [2:0] pend_q;
  logic nv_q;
  logic [1:0] nb_q;
  logic [7:0] v;
  int n_errors = 0;
  int n_compared = 0;

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  ctc_tx_request_ctrl u_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_wr_mask(reg_wr_mask),
    .reg_rd_en(reg_rd_en), .reg_rd_data_q(rd_q), .request_pin(request_pin),
    .eng_sent(eng_sent), .eng_lost_arb(eng_lost_arb), .eng_bus_err(eng_bus_err),
    .eng_buf(eng_buf), .pending_transmit_q(pend_q), .next_valid_q(nv_q),
    .next_buf_q(nb_q));

  ctc_eng_model u_eng (.clk(clk), .eng_sent(eng_sent), .eng_lost_arb(eng_lost_arb),
    .eng_bus_err(eng_bus_err), .eng_buf(eng_buf));

  // Masked write, one strobe cycle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clk);
    reg_addr <= a;
    reg_wr_data <= d;
    reg_wr_mask <= m;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask

  // Read; data is registered at the taking edge and sampled just after it.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    d = rd_q;
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    // Reset values, pins idle high, and an unmapped place.
    rd(OFS_TXB0, v); `CHK("txb0 rst", 8'h00, v)
    rd(OFS_TXB2, v); `CHK("txb2 rst", 8'h00, v)
    rd(OFS_PIN_CTRL, v); `CHK("pins rst", 8'h38, v)
    rd(8'h31, v); `CHK("unmapped", 8'h00, v)
    `CHK("valid rst", 1'b0, nv_q)
    $display("test reset done");
    // Request, then a good send clears pending and leaves aborted clear.
    wr(OFS_TXB0, 8'h0b, 8'hff);
    rd(OFS_TXB0, v); `CHK("txb0 pend", 8'h0b, v)
    u_eng.fire(3'b001, 2'h0);
    rd(OFS_TXB0, v); `CHK("txb0 sent", 8'h03, v)
    $display("test send done");
    // Lost arbitration and bus error, then a host abort.
    wr(OFS_TXB1, 8'h08, 8'hff);
    u_eng.fire(3'b010, 2'h1);
    u_eng.fire(3'b100, 2'h1);
    rd(OFS_TXB1, v); `CHK("txb1 flags", 8'h38, v)
    wr(OFS_TXB1, 8'h00, 8'h08);
    rd(OFS_TXB1, v); `CHK("txb1 abort", 8'h70, v)
    u_eng.fire(3'b001, 2'h1);
    rd(OFS_TXB1, v); `CHK("txb1 stale", 8'h70, v)
    $display("test abort done");
    // Pin 0 in request mode falls; pin 1 in input mode falls too.
    wr(OFS_PIN_CTRL, 8'h01, 8'hff);
    @(posedge clk);
    request_pin <= 3'h4;
    for (int i = 0; i < 10 && pend_q[0] !== 1'b1; i++)
    begin
      @(posedge clk);
      #1;
    end
    `CHK("pin req", 3'h1, pend_q)
    rd(OFS_PIN_CTRL, v); `CHK("pin state", 8'h21, v)
    $display("test pins done");
    // Priority order, then a tie with read-only bits written as ones.
    wr(OFS_TXB2, 8'h08, 8'hff);
    repeat (3) @(posedge clk);
    #1;
    `CHK("valid", 1'b1, nv_q)
    `CHK("prio hi", 2'h0, nb_q)
    wr(OFS_TXB2, 8'h7b, 8'hff);
    repeat (3) @(posedge clk);
    #1;
    `CHK("prio tie", 2'h2, nb_q)
    rd(OFS_TXB2, v); `CHK("txb2 ro", 8'h0b, v)
    // Abort buffer 2, drop buffer 0 to lowest, then buffer 1 at level 10 must lead.
    wr(OFS_TXB2, 8'h00, 8'h08);
    wr(OFS_TXB0, 8'h00, 8'h03);
    wr(OFS_TXB1, 8'h0a, 8'hff);
    repeat (3) @(posedge clk);
    #1;
    `CHK("prio mid", 2'h1, nb_q)
    rd(OFS_TXB2, v); `CHK("txb2 abort", 8'h43, v)
    $display("test priority done");
    close_out();
  end

  // Hang guard.
  initial
  begin
    #100000;
    n_errors++;
    close_out();
  end
endmodule
